/* hw/usc_pkg.sv */
package usc_pkg;

  // ***********************************************************************
  // Bus and data widths
  // ***********************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CHAR_W = 8;
  localparam int LEVEL_W = 7;

  // ***********************************************************************
  // Register byte offsets
  // ***********************************************************************
  localparam logic [7:0] OFS_LINE_CTRL = 8'h00;
  localparam logic [7:0] OFS_STOP2_MODEM = 8'h04;
  localparam logic [7:0] OFS_FEATURE = 8'h08;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0c;
  localparam logic [7:0] OFS_IRQ_IDENT = 8'h10;
  localparam logic [7:0] OFS_TRIGGER = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
  localparam logic [7:0] OFS_RX_LEVEL = 8'h20;

  // ***********************************************************************
  // Key values and field positions
  // ***********************************************************************
  localparam logic [7:0] LINE_CTRL_ENH_KEY = 8'hbf;
  localparam int FEAT_AUTO_RTS = 6;
  localparam int FEAT_SPEC_DET = 3;
  localparam int FEAT_SEL_LO = 0;
  localparam logic [1:0] SEL_FIRST_PAIR = 2'h2;
  localparam logic [1:0] SEL_SECOND_PAIR = 2'h1;
  localparam int IER_SPEC_BIT = 5;
  localparam int IIR_SPEC_BIT = 4;
  localparam int IIR_NONE_BIT = 0;
  localparam int MODEM_RTS_BIT = 1;
  localparam int EVT_SPEC = 0;
  localparam int EVT_STOP = 1;
  localparam int EVT_RTS_DROP = 2;
  localparam int EVT_W = 3;

  // ***********************************************************************
  // Reset values
  // ***********************************************************************
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [LEVEL_W-1:0] RST_TRIGGER = 7'h08;
  localparam logic [EVT_W-1:0] RST_EVT = 3'h0;

endpackage

/* hw/usc_char_match.sv */
`timescale 1ns/1ps

// Compares each received character with the second stop character and
// forwards it to the receive FIFO unless it is a stop character to swallow.
module usc_char_match
  import usc_pkg::*;
(
  input wire logic mclk, // System clock.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic rx_valid, // One-cycle strobe with a received character.
  input wire logic [usc_pkg::CHAR_W-1:0] rx_char, // Received character.
  input wire logic [usc_pkg::CHAR_W-1:0] stop2, // Second stop character.
  input wire logic det_en, // Special character detect enable.
  input wire logic [1:0] sel, // Software flow control pair select.
  output logic fifo_wr_en, // Write strobe into the receive FIFO.
  output logic [usc_pkg::CHAR_W-1:0] fifo_wr_data, // Character for the FIFO.
  output logic special_hit, // Pulse: special character matched.
  output logic stop_hit, // Pulse: second stop character swallowed.
  output logic char_done // Pulse: a character was received.
);

  logic eq;
  logic next_wr;
  logic next_spec;
  logic next_stop;
  logic [CHAR_W-1:0] next_data;

  // Whole-byte compare, bit 0 against the first received bit.
  always_comb
  begin
    eq = (rx_char == stop2);
    next_spec = rx_valid && det_en && eq;
    next_stop = rx_valid && (sel == SEL_SECOND_PAIR) && eq;
    next_wr = rx_valid && !next_stop;
    next_data = rx_valid ? rx_char : fifo_wr_data;
  end

  // Results are registered so the FIFO sees a clean strobe with its data.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      fifo_wr_en <= 1'b0;
      fifo_wr_data <= RST_REG8;
      special_hit <= 1'b0;
      stop_hit <= 1'b0;
      char_done <= 1'b0;
    end
    else
    begin
      fifo_wr_en <= next_wr;
      fifo_wr_data <= next_data;
      special_hit <= next_spec;
      stop_hit <= next_stop;
      char_done <= rx_valid;
    end
  end

  store_char_a: assert property (@(posedge mclk) disable iff (!nrst)
    (rx_valid && !(sel == SEL_SECOND_PAIR && rx_char == stop2))
    |=> (fifo_wr_en && fifo_wr_data == $past(rx_char)))
    else $error("Received character not written to FIFO.");

  stop_drop_a: assert property (@(posedge mclk) disable iff (!nrst)
    (rx_valid && sel == SEL_SECOND_PAIR && rx_char == stop2) |=> (!fifo_wr_en && stop_hit))
    else $error("Second stop character reached the FIFO.");

  detect_cmp_a: assert property (@(posedge mclk) disable iff (!nrst)
    (rx_valid && det_en) |=> (special_hit == ($past(rx_char) == $past(stop2))))
    else $error("Special character compare result wrong.");

endmodule

/* hw/usc_rts_ctrl.sv */
`timescale 1ns/1ps

// Drives the request-to-send pin, either from software or from the
// receive FIFO fill level against the trigger level.
module usc_rts_ctrl
  import usc_pkg::*;
(
  input wire logic mclk, // System clock.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic auto_en, // Automatic request-to-send enable.
  input wire logic sw_rts, // Software request: 1 drives the pin to logic 0.
  input wire logic [usc_pkg::LEVEL_W-1:0] level, // Receive FIFO fill level.
  input wire logic [usc_pkg::LEVEL_W-1:0] trig, // Receive trigger level.
  output logic rts_n, // Request-to-send pin, active low.
  output logic rts_drop // Pulse: automatic control released the pin.
);

  logic want_active;
  logic next_rts_n;
  logic next_drop;

  // Automatic control only gates an already asserted software request.
  always_comb
  begin
    if (auto_en && sw_rts)
      want_active = (level < trig);
    else
      want_active = sw_rts;
    next_rts_n = !want_active;
    next_drop = auto_en && sw_rts && (level >= trig) && !rts_n;
  end

  // The pin comes from a flip-flop so it never glitches on a level change.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      rts_n <= 1'b1;
      rts_drop <= 1'b0;
    end
    else
    begin
      rts_n <= next_rts_n;
      rts_drop <= next_drop;
    end
  end

  rts_auto_a: assert property (@(posedge mclk) disable iff (!nrst)
    (auto_en && sw_rts && level >= trig) |=> rts_n)
    else $error("RTS still active at trigger level.");

  rts_manual_a: assert property (@(posedge mclk) disable iff (!nrst)
    (!auto_en) |=> (rts_n == !$past(sw_rts)))
    else $error("RTS does not follow software when automatic control is off.");

endmodule

/* hw/usc_uart_special_char.sv */
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps

// Summary of operation
// - Setting the automatic request-to-send bit of the feature register hands RTS to flow control while the RTS bit of the modem control register is set.
// - With automatic control on, RTS goes inactive once the receive FIFO reaches the trigger level.
// - Without hardware flow control RTS is a software output, and automatic control is off at reset.
// - With special detect enabled, every received character is compared with the second stop character.
// - The second stop character sits at offset 0x4 while the line control register holds 0xbf.
// - A character that matches the special character is still written to the receive FIFO, except with select bits 01.
// - A special match sets bit 4 of the interrupt identification when bit 5 of the enable is set.
// - The compare is bit aligned, bit 0 of the stored value against the first received bit.
// - With select bits 10, flow control and special detection both work independently.
// - With select bits 01, a second stop character is kept out of the FIFO and raises an interrupt.
// - A pending special character indication clears by itself on the next received character.
module usc_uart_special_char
  import usc_pkg::*;
(
  input wire logic mclk, // System clock, 100 MHz.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [usc_pkg::ADDR_W-1:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte lane selects.
  input wire logic [usc_pkg::DATA_W-1:0] wb_dat_i, // Wishbone write data.
  output logic [usc_pkg::DATA_W-1:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  input wire logic rx_char_valid, // One-cycle strobe from the receiver.
  input wire logic [usc_pkg::CHAR_W-1:0] rx_char, // Received character.
  input wire logic [usc_pkg::LEVEL_W-1:0] rx_fifo_level, // Receive FIFO fill.
  output logic fifo_wr_en, // Receive FIFO write strobe.
  output logic [usc_pkg::CHAR_W-1:0] fifo_wr_data, // Receive FIFO write data.
  output logic stop_char_seen, // Pulse to the flow control on a stop character.
  output logic rts_n, // Request-to-send pin, active low.
  output logic irq // Interrupt, active high level.
);

  // ***********************************************************************
  // Declarations
  // ***********************************************************************
  logic [7:0] line_ctrl;
  logic [7:0] second_stop_character;
  logic [7:0] modem_ctrl;
  logic [7:0] enhanced_feature_ctrl;
  logic [7:0] irq_enable_reg;
  logic [LEVEL_W-1:0] trigger_level;
  logic [EVT_W-1:0] irq_status;
  logic [EVT_W-1:0] irq_mask;
  logic spec_flag;
  logic [7:0] next_line_ctrl;
  logic [7:0] next_second_stop_character;
  logic [7:0] next_modem_ctrl;
  logic [7:0] next_enhanced_feature_ctrl;
  logic [7:0] next_irq_enable_reg;
  logic [LEVEL_W-1:0] next_trigger_level;
  logic [EVT_W-1:0] next_irq_status;
  logic [EVT_W-1:0] next_irq_mask;
  logic next_spec_flag;
  logic next_ack;
  logic [DATA_W-1:0] next_dat;
  logic req;
  logic wr;
  logic enh_bank;
  logic [7:0] irq_identify;
  logic [7:0] wbyte;
  logic [EVT_W-1:0] events;
  logic special_hit;
  logic stop_hit;
  logic char_done;
  logic rts_drop;

  // ***********************************************************************
  // Address decode
  // ***********************************************************************

  // Word-aligned compare; the two low address bits are ignored.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] adr, input logic [ADDR_W-1:0] ofs);
    reg_hit = (adr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  // A request is taken once; the ack term blocks a second take in the
  // cycle where ack is already high and the master has not yet let go.
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];
  assign enh_bank = (line_ctrl == LINE_CTRL_ENH_KEY);

  // ***********************************************************************
  // Submodules
  // ***********************************************************************

  // Character compare and FIFO forwarding.
  usc_char_match u_match (
    .mclk(mclk),
    .nrst(nrst),
    .rx_valid(rx_char_valid),
    .rx_char(rx_char),
    .stop2(second_stop_character),
    .det_en(enhanced_feature_ctrl[FEAT_SPEC_DET]),
    .sel(enhanced_feature_ctrl[FEAT_SEL_LO +: 2]),
    .fifo_wr_en(fifo_wr_en),
    .fifo_wr_data(fifo_wr_data),
    .special_hit(special_hit),
    .stop_hit(stop_hit),
    .char_done(char_done)
  );

  // Request-to-send pin control.
  usc_rts_ctrl u_rts (
    .mclk(mclk),
    .nrst(nrst),
    .auto_en(enhanced_feature_ctrl[FEAT_AUTO_RTS]),
    .sw_rts(modem_ctrl[MODEM_RTS_BIT]),
    .level(rx_fifo_level),
    .trig(trigger_level),
    .rts_n(rts_n),
    .rts_drop(rts_drop)
  );

  assign stop_char_seen = stop_hit;

  // ***********************************************************************
  // Register file
  // ***********************************************************************

  // Software writes; only the low byte lane carries data.
  always_comb
  begin
    next_line_ctrl = line_ctrl;
    next_second_stop_character = second_stop_character;
    next_modem_ctrl = modem_ctrl;
    next_enhanced_feature_ctrl = enhanced_feature_ctrl;
    next_irq_enable_reg = irq_enable_reg;
    next_trigger_level = trigger_level;
    next_irq_mask = irq_mask;
    if (wr)
    begin
      if (reg_hit(wb_adr_i, OFS_LINE_CTRL))
        next_line_ctrl = wbyte;
      if (reg_hit(wb_adr_i, OFS_STOP2_MODEM) && enh_bank)
        next_second_stop_character = wbyte;
      if (reg_hit(wb_adr_i, OFS_STOP2_MODEM) && !enh_bank)
        next_modem_ctrl = wbyte;
      if (reg_hit(wb_adr_i, OFS_FEATURE))
        next_enhanced_feature_ctrl = wbyte;
      if (reg_hit(wb_adr_i, OFS_IRQ_ENABLE))
        next_irq_enable_reg = wbyte;
      if (reg_hit(wb_adr_i, OFS_TRIGGER))
        next_trigger_level = wbyte[LEVEL_W-1:0];
      if (reg_hit(wb_adr_i, OFS_IRQ_MASK))
        next_irq_mask = wbyte[EVT_W-1:0];
    end
  end

  // All control starts cleared except the trigger level, which loads 8, so both automatic features are off.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      line_ctrl <= RST_REG8;
      second_stop_character <= RST_REG8;
      modem_ctrl <= RST_REG8;
      enhanced_feature_ctrl <= RST_REG8;
      irq_enable_reg <= RST_REG8;
      trigger_level <= RST_TRIGGER;
      irq_mask <= RST_EVT;
    end
    else
    begin
      line_ctrl <= next_line_ctrl;
      second_stop_character <= next_second_stop_character;
      modem_ctrl <= next_modem_ctrl;
      enhanced_feature_ctrl <= next_enhanced_feature_ctrl;
      irq_enable_reg <= next_irq_enable_reg;
      trigger_level <= next_trigger_level;
      irq_mask <= next_irq_mask;
    end
  end

  // ***********************************************************************
  // Special character flag and interrupts
  // ***********************************************************************

  assign events = {rts_drop, stop_hit, special_hit};

  // The identification flag drops on the next character unless that one
  // matches with bit 5 of the enable set; such a match wins over the automatic clear.
  // Sticky status bits likewise keep a new event over a write-one clear.
  always_comb
  begin
    next_spec_flag = spec_flag;
    if (char_done)
      next_spec_flag = 1'b0;
    if (special_hit && irq_enable_reg[IER_SPEC_BIT])
      next_spec_flag = 1'b1;
    next_irq_status = irq_status;
    if (wr && reg_hit(wb_adr_i, OFS_IRQ_STATUS))
      next_irq_status = irq_status & ~wbyte[EVT_W-1:0];
    next_irq_status = next_irq_status | events;
  end

  // Flag and status registers.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      spec_flag <= 1'b0;
      irq_status <= RST_EVT;
    end
    else
    begin
      spec_flag <= next_spec_flag;
      irq_status <= next_irq_status;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Identification byte: bit 0 low while an interrupt is pending.
  always_comb
  begin
    irq_identify = RST_REG8;
    irq_identify[IIR_SPEC_BIT] = spec_flag;
    irq_identify[IIR_NONE_BIT] = !irq;
  end

  // ***********************************************************************
  // Bus answer
  // ***********************************************************************

  // Every access, mapped or not, is acked one cycle after it is taken;
  // unmapped reads return zero and unmapped writes are dropped.
  always_comb
  begin
    next_ack = req;
    next_dat = '0;
    if (req && !wb_we_i)
    begin
      if (reg_hit(wb_adr_i, OFS_LINE_CTRL))
        next_dat[7:0] = line_ctrl;
      else if (reg_hit(wb_adr_i, OFS_STOP2_MODEM))
        next_dat[7:0] = enh_bank ? second_stop_character : modem_ctrl;
      else if (reg_hit(wb_adr_i, OFS_FEATURE))
        next_dat[7:0] = enhanced_feature_ctrl;
      else if (reg_hit(wb_adr_i, OFS_IRQ_ENABLE))
        next_dat[7:0] = irq_enable_reg;
      else if (reg_hit(wb_adr_i, OFS_IRQ_IDENT))
        next_dat[7:0] = irq_identify;
      else if (reg_hit(wb_adr_i, OFS_TRIGGER))
        next_dat[LEVEL_W-1:0] = trigger_level;
      else if (reg_hit(wb_adr_i, OFS_IRQ_STATUS))
        next_dat[EVT_W-1:0] = irq_status;
      else if (reg_hit(wb_adr_i, OFS_IRQ_MASK))
        next_dat[EVT_W-1:0] = irq_mask;
      else if (reg_hit(wb_adr_i, OFS_RX_LEVEL))
        next_dat[LEVEL_W-1:0] = rx_fifo_level;
    end
  end

  // Ack and data come from flip-flops.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // ***********************************************************************
  // Checks
  // ***********************************************************************

  sequence stop2_write_s;
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && enh_bank &&
      reg_hit(wb_adr_i, OFS_STOP2_MODEM);
  endsequence

  sequence spec_match_s;
    rx_char_valid && enhanced_feature_ctrl[FEAT_SPEC_DET] &&
      rx_char == second_stop_character && irq_enable_reg[IER_SPEC_BIT];
  endsequence

  stop2_access_a: assert property (@(posedge mclk) disable iff (!nrst)
    stop2_write_s |=> (wb_ack_o && second_stop_character == $past(wb_dat_i[7:0])))
    else $error("Second stop character write not stored.");

  spec_flag_set_a: assert property (@(posedge mclk) disable iff (!nrst)
    spec_match_s |-> ##2 (spec_flag && irq_status[EVT_SPEC]))
    else $error("Special match did not raise the flag.");

  spec_auto_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
    (char_done && !special_hit && !$past(special_hit)) |=> !spec_flag)
    else $error("Special flag not cleared by the next character.");

  reset_feature_a: assert property (@(posedge mclk) disable iff (!nrst)
    ($past(!nrst)) |-> (enhanced_feature_ctrl == RST_REG8 && !spec_flag))
    else $error("Feature bits not cleared by reset.");

  ack_pulse_a: assert property (@(posedge mclk) disable iff (!nrst)
    wb_ack_o |=> !wb_ack_o)
    else $error("Ack held for more than one cycle.");

  irq_level_a: assert property (@(posedge mclk) disable iff (!nrst)
    (special_hit && irq_mask[EVT_SPEC]) |=> irq)
    else $error("Unmasked event did not raise the interrupt.");

  // Sticky status: without a write-one clear no bit may fall.
  status_sticky_a: assert property (@(posedge mclk) disable iff (!nrst)
    !(wr && reg_hit(wb_adr_i, OFS_IRQ_STATUS))
    |=> ((irq_status & $past(irq_status)) == $past(irq_status)))
    else $error("Status bit lost without a clear.");

  // A clear with no event in the same cycle must take every written one.
  status_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
    (wr && reg_hit(wb_adr_i, OFS_IRQ_STATUS) && events == RST_EVT)
    |=> ((irq_status & $past(wbyte[EVT_W-1:0])) == RST_EVT))
    else $error("Write-one clear left a status bit set.");

  reset_outputs_a: assert property (@(posedge mclk) disable iff (!nrst)
    ($past(!nrst)) |-> (rts_n && !wb_ack_o && !irq && !fifo_wr_en))
    else $error("Outputs not idle after reset.");

  spec_no_enable_a: assert property (@(posedge mclk) disable iff (!nrst)
    (special_hit && !irq_enable_reg[IER_SPEC_BIT]) |=> !spec_flag)
    else $error("Special flag set with its enable off.");

  // The RTS release and stop character pulses must land in their sticky status bits one cycle later.
  rts_event_a: assert property (@(posedge mclk) disable iff (!nrst)
    rts_drop |=> irq_status[EVT_RTS_DROP])
    else $error("Automatic RTS release not recorded.");

  stop_event_a: assert property (@(posedge mclk) disable iff (!nrst)
    stop_hit |=> irq_status[EVT_STOP])
    else $error("Second stop character not recorded.");

endmodule

/* verification/usc_remote_tx.sv */
`timescale 1ns/1ps

// ***********************************************************************
// Remote transmitter and receive FIFO fill model
// ***********************************************************************
// Sends characters only while the block asks for data, and counts what
// the block writes into the receive FIFO so the bench can judge it.
module usc_remote_tx
  import usc_pkg::*;
(
  input wire logic mclk, // System clock.
  input wire logic rts_n, // Flow control from the block.
  input wire logic fifo_wr_en, // FIFO write strobe.
  input wire logic [usc_pkg::CHAR_W-1:0] fifo_wr_data, // FIFO write data.
  input wire logic stop_char_seen, // Swallowed stop character.
  input wire logic drain, // Empties the modelled FIFO.
  output logic rx_char_valid, // Character strobe.
  output logic [usc_pkg::CHAR_W-1:0] rx_char, // Character.
  output logic [usc_pkg::LEVEL_W-1:0] level // FIFO fill.
);
  int wr_cnt = 0;
  int stop_cnt = 0;
  logic [usc_pkg::CHAR_W-1:0] last = 8'h00;

  // Quiet line at time zero.
  initial
  begin
    rx_char_valid = 1'b0;
    rx_char = 8'h00;
    level = 7'h00;
  end

  // Holds off while the pin is high; the data line then shows a changed value.
  task automatic send(input logic [usc_pkg::CHAR_W-1:0] c);
    do @(posedge mclk); while (rts_n !== 1'b0);
    rx_char_valid <= 1'b1;
    rx_char <= c;
    @(posedge mclk);
    rx_char_valid <= 1'b0;
    rx_char <= ~c;
    repeat (3) @(posedge mclk);
  endtask

  // Fill level and write log, as a real FIFO would see them.
  always @(posedge mclk)
  begin
    if (drain)
      level <= 7'h00;
    else if (fifo_wr_en === 1'b1)
      level <= level + 7'h01;
    if (fifo_wr_en === 1'b1)
    begin
      wr_cnt <= wr_cnt + 1;
      last <= fifo_wr_data;
    end
    if (stop_char_seen === 1'b1)
      stop_cnt <= stop_cnt + 1;
  end
endmodule

/* verification/usc_uart_special_char_test.sv */
`timescale 1ns/1ps

// ***********************************************************************
// Bench for special character detection and automatic RTS
// ***********************************************************************
module usc_uart_special_char_test;
  import usc_pkg::*;
  localparam logic [31:0] ALL = 32'hffffffff;
  logic mclk = 1'b0;
  logic nrst, cyc, stb, we, rx_valid, wr_en, stop_seen, rts_n, irq, ack, drain;
  logic [7:0] adr, rx_char, wr_data;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rv;
  logic [LEVEL_W-1:0] level;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;

  usc_uart_special_char dut_u (.mclk(mclk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rx_char_valid(rx_valid), .rx_char(rx_char), .rx_fifo_level(level),
    .fifo_wr_en(wr_en), .fifo_wr_data(wr_data), .stop_char_seen(stop_seen),
    .rts_n(rts_n), .irq(irq));

  usc_remote_tx part_u (.mclk(mclk), .rts_n(rts_n), .fifo_wr_en(wr_en),
    .fifo_wr_data(wr_data), .stop_char_seen(stop_seen), .drain(drain),
    .rx_char_valid(rx_valid), .rx_char(rx_char), .level(level));

  // Free-running 100 MHz clock.
  initial
  begin
    forever #5 mclk = ~mclk;
  end

  // A hang is cut short well above the few hundred cycles the run needs.
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One classic cycle; the answer is taken at the edge that sees ack.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (ack !== 1'b1 && n < 100);
    if (n >= 100)
      fail_count++;
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge mclk); // Outputs launched at the ack edge settle before the caller looks.
  endtask

  // Upper data bits are filled on purpose: the block must ignore them.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, {24'hc3c3c3, d}, 4'h1);
  endtask

  task automatic rdm(input string nm, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(nm, rv & m, e);
  endtask

  // Empties the modelled FIFO and lets the pin settle.
  task automatic empty_fifo();
    @(posedge mclk);
    drain <= 1'b1;
    @(posedge mclk);
    drain <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  // Main sequence.
  initial
  begin
    nrst = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    drain = 1'b0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    chk("rts_n", rts_n, 32'h1);
    rdm("feature", OFS_FEATURE, ALL, 32'h00);
    rdm("trigger", OFS_TRIGGER, ALL, 32'h08);
    wb(1'b1, OFS_TRIGGER, 32'h00000033, 4'he);
    rdm("trigger lane", OFS_TRIGGER, ALL, 32'h08);
    rdm("unmapped", 8'h40, ALL, 32'h00);
    wr(OFS_LINE_CTRL, LINE_CTRL_ENH_KEY);
    wr(OFS_STOP2_MODEM, 8'h5a);
    rdm("stop2", OFS_STOP2_MODEM, ALL, 32'h5a);
    wr(OFS_LINE_CTRL, 8'h00);
    rdm("modem", OFS_STOP2_MODEM, ALL, 32'h00);
    wr(OFS_STOP2_MODEM, 8'h02);
    chk("rts_n", rts_n, 32'h0);
    wr(OFS_IRQ_MASK, 8'h07);
    wr(OFS_IRQ_ENABLE, 8'h20);
    part_u.send(8'h5a);
    rdm("status", OFS_IRQ_STATUS, ALL, 32'h00);
    wr(OFS_FEATURE, 8'h0a);
    part_u.send(8'h5a);
    rdm("status", OFS_IRQ_STATUS, ALL, 32'h01);
    rdm("ident", OFS_IRQ_IDENT, 32'h10, 32'h10);
    chk("irq", irq, 32'h1);
    chk("fifo data", part_u.last, 32'h5a);
    chk("fifo count", part_u.wr_cnt, 32'h2);
    wr(OFS_IRQ_STATUS, 8'h01);
    chk("irq", irq, 32'h0);
    part_u.send(8'ha5);
    rdm("ident", OFS_IRQ_IDENT, 32'h10, 32'h00);
    rdm("status", OFS_IRQ_STATUS, ALL, 32'h00);
    wr(OFS_IRQ_ENABLE, 8'h00);
    part_u.send(8'h5a);
    rdm("ident", OFS_IRQ_IDENT, 32'h10, 32'h00);
    rdm("status", OFS_IRQ_STATUS, ALL, 32'h01);
    wr(OFS_IRQ_MASK, 8'h06);
    chk("irq masked", irq, 32'h0);
    rdm("mask", OFS_IRQ_MASK, ALL, 32'h06);
    wr(OFS_IRQ_STATUS, 8'h07);
    wr(OFS_FEATURE, 8'h09);
    part_u.send(8'h5a);
    part_u.send(8'h33);
    chk("fifo count", part_u.wr_cnt, 32'h5);
    chk("fifo data", part_u.last, 32'h33);
    chk("stop count", part_u.stop_cnt, 32'h1);
    rdm("status", OFS_IRQ_STATUS, 32'h02, 32'h02);
    wr(OFS_IRQ_STATUS, 8'h07);
    wr(OFS_TRIGGER, 8'h04);
    empty_fifo();
    wr(OFS_FEATURE, 8'h40);
    repeat (3) part_u.send(8'h11);
    chk("rts_n", rts_n, 32'h0);
    part_u.send(8'h11);
    chk("rts_n", rts_n, 32'h1);
    rdm("status", OFS_IRQ_STATUS, 32'h04, 32'h04);
    empty_fifo();
    chk("rts_n", rts_n, 32'h0);
    wr(OFS_STOP2_MODEM, 8'h00);
    chk("rts_n", rts_n, 32'h1);
    wr(OFS_FEATURE, 8'h00);
    wr(OFS_STOP2_MODEM, 8'h02);
    repeat (5) part_u.send(8'h22);
    chk("rts_n", rts_n, 32'h0);
    // A second reset in mid-run must bring the RTS pin and the feature and modem control registers back to their reset values.
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    chk("rts_n", rts_n, 32'h1);
    rdm("feature", OFS_FEATURE, ALL, 32'h00);
    rdm("modem", OFS_STOP2_MODEM, ALL, 32'h00);
    summarize();
  end
endmodule
